// ---- hdl/cthl_pkg.sv ----
/*
 * Constants for the cyclic timer and hardware lock configuration bank.
 * Assumes a 25 MHz core clock and 7-bit register addresses from the
 * serial frame decoder.
 */
`default_nettype none
package cthl_pkg;
	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [6:0] CTHL_TIMER_CTRL_ADDR = 7'h0c;
	localparam logic [6:0] CTHL_HW_CTRL_ONE_ADDR = 7'h0e;
	localparam logic [6:0] CTHL_CP_CTRL_ADDR = 7'h15;
	localparam logic [6:0] CTHL_GPIO_CTRL_ADDR = 7'h17;

	// ------------------------------------------------------------------
	// Field positions and masks
	// ------------------------------------------------------------------
	localparam int CTHL_HYS_BIT = 7;
	localparam int CTHL_TSD_BIT = 5;
	localparam int CTHL_RDEL_BIT = 4;
	localparam int CTHL_LOCK0_BIT = 3;
	localparam int CTHL_CP_BIT = 0;
	localparam logic [7:0] CTHL_HW_WR_MASK = 8'hb8;
	localparam logic [7:0] CTHL_HW_L1_MASK = 8'hb0;
	localparam logic [7:0] CTHL_HW_L0_MASK = 8'h08;
	localparam logic [7:0] CTHL_TIMER_MASK = 8'h7f;
	localparam logic [7:0] CTHL_GPIO_MASK = 8'h07;
	localparam logic [7:0] CTHL_CP_MASK = 8'h01;
	localparam logic [7:0] CTHL_ZERO8 = 8'h00;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	localparam logic [2:0] CTHL_GPIO_CYC_SENSE = 3'h3;
	localparam logic [2:0] CTHL_GPIO_RESET_VAL = 3'h0;
	localparam logic [2:0] CTHL_ON_OFF_LOW = 3'h0;
	localparam logic [2:0] CTHL_ON_OFF_HIGH = 3'h6;
	localparam logic [2:0] CTHL_ON_RSVD = 3'h7;
	localparam logic [4:0] CTHL_TSD_STREAK_LIMIT = 5'h10;

	// ------------------------------------------------------------------
	// Timing: all intervals are counted in 0.1 ms ticks
	// ------------------------------------------------------------------
	localparam int CTHL_CLK_PERIOD_NS = 40;
	localparam int CTHL_TICK_TIME_NS = 100000;
	localparam int CTHL_TICK_CYCLES =
		(CTHL_TICK_TIME_NS + CTHL_CLK_PERIOD_NS - 1) / CTHL_CLK_PERIOD_NS;
	localparam int CTHL_CNT_W = 24;

	typedef logic [CTHL_CNT_W-1:0] cthl_cnt_t;

	// Period in ticks: 10 ms to 1000 s in a 1-2-5 progression.
	function automatic cthl_cnt_t cthl_period_ticks(input logic [3:0] sel);
		unique case (sel)
			4'h0: cthl_period_ticks = 24'h00_0064;
			4'h1: cthl_period_ticks = 24'h00_00c8;
			4'h2: cthl_period_ticks = 24'h00_01f4;
			4'h3: cthl_period_ticks = 24'h00_03e8;
			4'h4: cthl_period_ticks = 24'h00_07d0;
			4'h5: cthl_period_ticks = 24'h00_1388;
			4'h6: cthl_period_ticks = 24'h00_2710;
			4'h7: cthl_period_ticks = 24'h00_4e20;
			4'h8: cthl_period_ticks = 24'h00_c350;
			4'h9: cthl_period_ticks = 24'h01_86a0;
			4'ha: cthl_period_ticks = 24'h03_0d40;
			4'hb: cthl_period_ticks = 24'h07_a120;
			4'hc: cthl_period_ticks = 24'h0f_4240;
			4'hd: cthl_period_ticks = 24'h1e_8480;
			4'he: cthl_period_ticks = 24'h4c_4b40;
			4'hf: cthl_period_ticks = 24'h98_9680;
		endcase
	endfunction : cthl_period_ticks

	// On-time in ticks: 0.1, 0.3, 1, 10, 20 ms; off codes give zero.
	function automatic cthl_cnt_t cthl_on_ticks(input logic [2:0] sel);
		unique case (sel)
			3'h1: cthl_on_ticks = 24'h00_0001;
			3'h2: cthl_on_ticks = 24'h00_0003;
			3'h3: cthl_on_ticks = 24'h00_000a;
			3'h4: cthl_on_ticks = 24'h00_0064;
			3'h5: cthl_on_ticks = 24'h00_00c8;
			default: cthl_on_ticks = 24'h00_0000;
		endcase
	endfunction : cthl_on_ticks
endpackage : cthl_pkg
`default_nettype wire

// ---- hdl/cthl_timer.sv ----
/*
 * Cyclic timer: runs period and on-time phases from 0.1 ms ticks.
 * Assumes settings are stable between reload pulses from the bank.
 */
`timescale 1ns/1ps
`default_nettype none
module cthl_timer #(
	parameter int TICK_CYCLES = cthl_pkg::CTHL_TICK_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Settings
	input wire logic [3:0] period_sel,
	input wire logic [2:0] on_sel,
	input wire logic reload,
	// Outputs
	output logic timer_level,
	output logic cycle_start
);
	import cthl_pkg::*;

	logic [15:0] pre_q;
	cthl_cnt_t per_q;
	logic tick;
	logic running;

	assign tick = (pre_q == 16'(TICK_CYCLES - 1));
	assign running = (on_sel != CTHL_ON_OFF_LOW) &&
		(on_sel != CTHL_ON_OFF_HIGH) && (on_sel != CTHL_ON_RSVD);

	// ------------------------------------------------------------------
	// Tick prescaler
	// ------------------------------------------------------------------
	// restart on reload
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 16'h0000;
		end else if (reload || tick) begin
			pre_q <= 16'h0000;
		end else begin
			pre_q <= pre_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Period counter and output phase
	// ------------------------------------------------------------------
	// period decode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			per_q <= '0;
		end else if (reload || !running) begin
			per_q <= '0;
		end else if (tick) begin
			if (per_q == cthl_period_ticks(period_sel) - 24'h00_0001) begin
				per_q <= '0;
			end else begin
				per_q <= per_q + 24'h00_0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_level <= 1'b0;
			cycle_start <= 1'b0;
		end else begin
			if (running) begin
				timer_level <= (per_q < cthl_on_ticks(on_sel));
			end else begin
				timer_level <= (on_sel == CTHL_ON_OFF_HIGH);
			end
			cycle_start <= running && !reload && tick &&
				(per_q == cthl_period_ticks(period_sel) - 24'h00_0001);
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_off_high_level;
		@(posedge core_clk) disable iff (!rst_n)
		(on_sel == CTHL_ON_OFF_HIGH) [*2] |-> timer_level;
	endproperty
	a_off_high_level: assert property (p_off_high_level)
		else $error("off-high code did not hold the output high");

	property p_no_cycle_when_off;
		@(posedge core_clk) disable iff (!rst_n)
		!running |-> ##1 (per_q == '0) && !cycle_start;
	endproperty
	a_no_cycle_when_off: assert property (p_no_cycle_when_off)
		else $error("timer counted while its on-time was off");
endmodule : cthl_timer
`default_nettype wire

// ---- hdl/cthl_top.sv ----
/*
 * Cyclic timer and hardware lock configuration bank. Assumes a frame
 * decoder on core_clk giving one-cycle write strobes, read data taken a
 * cycle after its address, and an asynchronous select pin synced here.
 */
`timescale 1ns/1ps
`default_nettype none
module cthl_top #(
	parameter int TICK_CYCLES = cthl_pkg::CTHL_TICK_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Serial frame side
	input wire logic serial_select_n,
	input wire logic wr_strobe,
	input wire logic [6:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [6:0] rd_addr,
	output logic [7:0] rd_data,
	// Mode events and status from the rest of the chip
	input wire logic soft_reset,
	input wire logic restart_entry,
	input wire logic hs_switch_cleared,
	input wire logic cfg_lock_level1,
	input wire logic timer_wake_en,
	input wire logic thermal_shutdown_level2,
	input wire logic thermal_streak_break,
	// Configuration outputs
	output logic uv_reset_hysteresis_sel,
	output logic thermal_release_wait_sel,
	output logic thermal_wait_x64,
	output logic reset_delay_sel,
	output logic charge_pump_enable,
	output logic [2:0] gpio_cfg,
	// Timer outputs
	output logic cyclic_sense_hs,
	output logic cyclic_wake_pulse
);
	import cthl_pkg::*;

	// ------------------------------------------------------------------
	// Select pin synchroniser and frame end
	// ------------------------------------------------------------------
	logic [2:0] sel_sync_q;
	logic sel_state_q;
	logic frame_end;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_sync_q <= 3'h7;
			sel_state_q <= 1'b1;
		end else begin
			sel_sync_q <= {sel_sync_q[1:0], serial_select_n};
			if (sel_sync_q[1] == sel_sync_q[2]) begin
				sel_state_q <= sel_sync_q[2];
			end
		end
	end

	assign frame_end = !sel_state_q && (sel_sync_q[1] == sel_sync_q[2]) &&
		sel_sync_q[2];

	// ------------------------------------------------------------------
	// Pending writes held until the frame ends
	// ------------------------------------------------------------------
	logic pend_q;
	logic [6:0] pend_addr_q;
	logic [7:0] pend_data_q;
	logic commit;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			pend_addr_q <= 7'h00;
			pend_data_q <= CTHL_ZERO8;
		end else if (wr_strobe) begin
			pend_q <= 1'b1;
			pend_addr_q <= wr_addr;
			pend_data_q <= wr_data;
		end else if (frame_end) begin
			pend_q <= 1'b0;
		end
	end

	assign commit = frame_end && pend_q;

	function automatic logic hit(input logic [6:0] a);
		hit = commit && (pend_addr_q == a);
	endfunction : hit

	// ------------------------------------------------------------------
	// Hardware control one
	// ------------------------------------------------------------------
	logic [7:0] hw_q;
	logic [7:0] hw_keep;
	logic lock0;

	assign lock0 = hw_q[CTHL_LOCK0_BIT];
	assign hw_keep = (cfg_lock_level1 ? CTHL_HW_L1_MASK : CTHL_ZERO8) |
		(lock0 ? CTHL_HW_L0_MASK : CTHL_ZERO8);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hw_q <= CTHL_ZERO8;
		end else if (restart_entry) begin
			hw_q <= hw_q & CTHL_HW_WR_MASK;
		end else if (soft_reset) begin
			hw_q <= hw_q & hw_keep;
		end else if (hit(CTHL_HW_CTRL_ONE_ADDR)) begin
			hw_q <= ((hw_q & CTHL_HW_L1_MASK & {8{cfg_lock_level1}}) |
				(pend_data_q & CTHL_HW_WR_MASK &
				~(CTHL_HW_L1_MASK & {8{cfg_lock_level1}})));
		end
	end

	// ------------------------------------------------------------------
	// Charge pump enable and pin configuration, level-0 lockable
	// ------------------------------------------------------------------
	logic cp_q;
	logic [2:0] gpio_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cp_q <= 1'b0;
			gpio_q <= CTHL_GPIO_RESET_VAL;
		end else if (soft_reset && !restart_entry) begin
			if (!lock0) begin
				cp_q <= 1'b0;
				gpio_q <= CTHL_GPIO_RESET_VAL;
			end
		end else if (!lock0) begin
			if (hit(CTHL_CP_CTRL_ADDR)) begin
				cp_q <= pend_data_q[CTHL_CP_BIT];
			end
			if (hit(CTHL_GPIO_CTRL_ADDR)) begin
				gpio_q <= pend_data_q[2:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Timer control
	// ------------------------------------------------------------------
	logic [6:0] tmr_q;
	logic tmr_reload_q;
	logic sense_sel;

	assign sense_sel = (gpio_q == CTHL_GPIO_CYC_SENSE);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_q <= 7'h00;
		end else if (restart_entry && sense_sel && hs_switch_cleared) begin
			tmr_q <= 7'h00;
		end else if (soft_reset) begin
			tmr_q <= 7'h00;
		end else if (hit(CTHL_TIMER_CTRL_ADDR)) begin
			tmr_q <= pend_data_q[6:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_reload_q <= 1'b0;
		end else begin
			tmr_reload_q <= hit(CTHL_TIMER_CTRL_ADDR) || soft_reset ||
				restart_entry;
		end
	end

	logic timer_level;
	logic cycle_start;

	cthl_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.period_sel(tmr_q[3:0]),
		.on_sel(tmr_q[6:4]),
		.reload(tmr_reload_q),
		.timer_level(timer_level),
		.cycle_start(cycle_start)
	);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyclic_sense_hs <= 1'b0;
			cyclic_wake_pulse <= 1'b0;
		end else begin
			cyclic_sense_hs <= sense_sel && timer_level;
			cyclic_wake_pulse <= timer_wake_en && cycle_start;
		end
	end

	// ------------------------------------------------------------------
	// Thermal shutdown streak
	// ------------------------------------------------------------------
	logic [4:0] tsd_cnt_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tsd_cnt_q <= 5'h00;
		end else if (thermal_streak_break) begin
			tsd_cnt_q <= 5'h00;
		end else if (thermal_shutdown_level2 &&
			tsd_cnt_q <= CTHL_TSD_STREAK_LIMIT) begin
			tsd_cnt_q <= tsd_cnt_q + 5'h01;
		end
	end

	// ------------------------------------------------------------------
	// Outputs and read data
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			uv_reset_hysteresis_sel <= 1'b0;
			thermal_release_wait_sel <= 1'b0;
			thermal_wait_x64 <= 1'b0;
			reset_delay_sel <= 1'b0;
			charge_pump_enable <= 1'b0;
			gpio_cfg <= CTHL_GPIO_RESET_VAL;
		end else begin
			uv_reset_hysteresis_sel <= hw_q[CTHL_HYS_BIT];
			thermal_release_wait_sel <= hw_q[CTHL_TSD_BIT];
			thermal_wait_x64 <= hw_q[CTHL_TSD_BIT] &&
				(tsd_cnt_q > CTHL_TSD_STREAK_LIMIT);
			reset_delay_sel <= hw_q[CTHL_RDEL_BIT];
			charge_pump_enable <= cp_q;
			gpio_cfg <= gpio_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= CTHL_ZERO8;
		end else begin
			unique case (rd_addr)
				CTHL_HW_CTRL_ONE_ADDR: rd_data <= hw_q & CTHL_HW_WR_MASK;
				CTHL_TIMER_CTRL_ADDR: rd_data <= {1'b0, tmr_q};
				CTHL_CP_CTRL_ADDR: rd_data <= {7'h00, cp_q};
				CTHL_GPIO_CTRL_ADDR: rd_data <= {5'h00, gpio_q};
				default: rd_data <= CTHL_ZERO8;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_timer_only_at_frame_end;
		@(posedge core_clk) disable iff (!rst_n)
		!frame_end && !soft_reset && !restart_entry |=> $stable(tmr_q);
	endproperty
	a_timer_only_at_frame_end: assert property (p_timer_only_at_frame_end)
		else $error("timer setting changed outside a frame end");
	property p_reserved_zero;
		@(posedge core_clk) disable iff (!rst_n)
		rd_addr == CTHL_HW_CTRL_ONE_ADDR |=> (rd_data & ~CTHL_HW_WR_MASK) == 0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits of hardware control one read nonzero");
	property p_lock0_blocks;
		@(posedge core_clk) disable iff (!rst_n)
		lock0 && !soft_reset |=> $stable(gpio_q) && $stable(cp_q);
	endproperty
	a_lock0_blocks: assert property (p_lock0_blocks)
		else $error("locked pin configuration or charge pump changed");
	property p_lock1_keeps;
		@(posedge core_clk) disable iff (!rst_n)
		cfg_lock_level1 && !restart_entry |=>
			($past(hw_q) & CTHL_HW_L1_MASK) == (hw_q & CTHL_HW_L1_MASK);
	endproperty
	a_lock1_keeps: assert property (p_lock1_keeps)
		else $error("level-1 locked bit changed");
	property p_soft_clears_unlocked;
		@(posedge core_clk) disable iff (!rst_n)
		soft_reset && !restart_entry && !cfg_lock_level1 |=>
			(hw_q & CTHL_HW_L1_MASK) == 0;
	endproperty
	a_soft_clears_unlocked: assert property (p_soft_clears_unlocked)
		else $error("soft reset left unlocked bits set");
	property p_restart_clears_timer;
		@(posedge core_clk) disable iff (!rst_n)
		restart_entry && sense_sel && hs_switch_cleared |=> tmr_q == 0;
	endproperty
	a_restart_clears_timer: assert property (p_restart_clears_timer)
		else $error("timer not cleared on restart with cyclic sense");
	property p_x64_needs_sel;
		@(posedge core_clk) disable iff (!rst_n)
		thermal_wait_x64 |-> $past(hw_q[CTHL_TSD_BIT]) &&
			$past(tsd_cnt_q) > CTHL_TSD_STREAK_LIMIT;
	endproperty
	a_x64_needs_sel: assert property (p_x64_needs_sel)
		else $error("thermal wait stretched without cause");
	property p_hys_follows;
		@(posedge core_clk) disable iff (!rst_n)
		hw_q[CTHL_HYS_BIT] [*2] |-> uv_reset_hysteresis_sel;
	endproperty
	a_hys_follows: assert property (p_hys_follows)
		else $error("hysteresis select output does not follow bit 7");
endmodule : cthl_top
`default_nettype wire

// ---- sim/cthl_host.sv ----
/*
 * Host model: drives write frames and register reads into the bank.
 * Assumes the bank's frame decoder ports and a free-running core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module cthl_host (
	// Clock
	input wire logic core_clk,
	// Frame side
	output logic serial_select_n,
	output logic wr_strobe,
	output logic [6:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [6:0] rd_addr,
	input wire logic [7:0] rd_data
);
	initial begin
		serial_select_n = 1'b1;
		wr_strobe = 1'b0;
		wr_addr = 7'h7f;
		wr_data = 8'h00;
		rd_addr = 7'h7f;
	end

	// ------------------------------------------------------------------
	// Frame tasks
	// ------------------------------------------------------------------
	// Released lines carry the inverse of the last byte, so a bank that
	// latches late cannot pick up a stale but matching value.
	task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
		@(negedge core_clk);
		serial_select_n = 1'b0;
		repeat (3) @(negedge core_clk);
		wr_strobe = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge core_clk);
		wr_strobe = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
		repeat (3) @(negedge core_clk);
		serial_select_n = 1'b1;
		repeat (10) @(negedge core_clk);
	endtask : write_reg

	task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
		@(negedge core_clk);
		rd_addr = a;
		repeat (2) @(negedge core_clk);
		d = rd_data;
		rd_addr = ~a;
	endtask : read_reg
endmodule : cthl_host
`default_nettype wire

// ---- sim/testbench.sv ----
/*
 * Self-checking bench for the cyclic timer and lock configuration bank.
 * Assumes the host model for frames and a shortened tick of 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cthl_pkg::*;
	localparam int TC = 4;
	logic core_clk = 1'b0;
	logic rst_n, serial_select_n, wr_strobe, soft_reset, restart_entry;
	logic hs_switch_cleared, cfg_lock_level1, timer_wake_en;
	logic thermal_shutdown_level2, thermal_streak_break;
	logic [6:0] wr_addr, rd_addr;
	logic [7:0] wr_data, rd_data;
	logic uv_reset_hysteresis_sel, thermal_release_wait_sel;
	logic thermal_wait_x64, reset_delay_sel, charge_pump_enable;
	logic cyclic_sense_hs, cyclic_wake_pulse;
	logic [2:0] gpio_cfg;
	int bad_count = 0;
	int tests_run = 0;
	int hi, per, n, k;
	int per_tk[3] = '{100, 200, 500};
	int on_tk[5] = '{1, 3, 10, 100, 200};
	logic [6:0] addrs[5] = '{7'h0c, 7'h0e, 7'h15, 7'h17, 7'h20};

	always #20 core_clk = ~core_clk;

	cthl_top #(.TICK_CYCLES(TC)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
		.serial_select_n(serial_select_n), .wr_strobe(wr_strobe),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
		.rd_data(rd_data), .soft_reset(soft_reset),
		.restart_entry(restart_entry), .hs_switch_cleared(hs_switch_cleared),
		.cfg_lock_level1(cfg_lock_level1), .timer_wake_en(timer_wake_en),
		.thermal_shutdown_level2(thermal_shutdown_level2),
		.thermal_streak_break(thermal_streak_break),
		.uv_reset_hysteresis_sel(uv_reset_hysteresis_sel),
		.thermal_release_wait_sel(thermal_release_wait_sel),
		.thermal_wait_x64(thermal_wait_x64),
		.reset_delay_sel(reset_delay_sel),
		.charge_pump_enable(charge_pump_enable), .gpio_cfg(gpio_cfg),
		.cyclic_sense_hs(cyclic_sense_hs),
		.cyclic_wake_pulse(cyclic_wake_pulse));

	cthl_host i_host (.core_clk(core_clk), .serial_select_n(serial_select_n),
		.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_addr(rd_addr), .rd_data(rd_data));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %0h expected %0h", $time,
				seen, exp);
		end
	endtask : check

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host.read_reg(a, d);
		check({24'h0000_00, d}, {24'h0000_00, e});
	endtask : rd_chk

	task automatic pulse(input int p);
		@(negedge core_clk);
		soft_reset = (p == 0);
		restart_entry = (p == 1);
		thermal_shutdown_level2 = (p == 2);
		thermal_streak_break = (p == 3);
		@(negedge core_clk);
		soft_reset = 1'b0;
		restart_entry = 1'b0;
		thermal_shutdown_level2 = 1'b0;
		thermal_streak_break = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask : pulse

	// Bounded loops keep a dead timer from hanging the run.
	task automatic measure(output int h, output int p);
		int c;
		h = 0;
		p = 0;
		c = 0;
		while (cyclic_sense_hs !== 1'b0 && c < 5000) begin
			@(negedge core_clk);
			c++;
		end
		while (cyclic_sense_hs !== 1'b1 && c < 10000) begin
			@(negedge core_clk);
			c++;
		end
		while (cyclic_sense_hs === 1'b1 && c < 15000) begin
			@(negedge core_clk);
			h++;
			c++;
		end
		p = h;
		while (cyclic_sense_hs === 1'b0 && c < 20000) begin
			@(negedge core_clk);
			p++;
			c++;
		end
	endtask : measure

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	initial begin
		repeat (95000) @(posedge core_clk);
		bad_count++;
		close_out();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		{soft_reset, restart_entry, hs_switch_cleared} = 3'h0;
		{cfg_lock_level1, timer_wake_en} = 2'h0;
		{thermal_shutdown_level2, thermal_streak_break} = 2'h0;
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		for (k = 0; k < 5; k++)
			rd_chk(addrs[k], 8'h00);
		check({29'h0, uv_reset_hysteresis_sel, thermal_release_wait_sel,
			reset_delay_sel}, 32'h0);
		i_host.write_reg(7'h0e, 8'hff);
		rd_chk(7'h0e, 8'hb8);
		check({29'h0, uv_reset_hysteresis_sel, thermal_release_wait_sel,
			reset_delay_sel}, 32'h7);
		// Lock 0 is set, so both writes must be dropped.
		i_host.write_reg(7'h15, 8'h01);
		i_host.write_reg(7'h17, 8'h03);
		rd_chk(7'h15, 8'h00);
		rd_chk(7'h17, 8'h00);
		repeat (16) pulse(2);
		check({31'h0, thermal_wait_x64}, 32'h0);
		pulse(2);
		check({31'h0, thermal_wait_x64}, 32'h1);
		pulse(3);
		check({31'h0, thermal_wait_x64}, 32'h0);
		i_host.write_reg(7'h0e, 8'hb0);
		i_host.write_reg(7'h15, 8'h01);
		i_host.write_reg(7'h17, 8'h03);
		rd_chk(7'h15, 8'h01);
		rd_chk(7'h17, 8'h03);
		check({28'h0, charge_pump_enable, gpio_cfg}, 32'hb);
		for (k = 0; k < 16; k++) begin
			i_host.write_reg(7'h0c, 8'(k));
			rd_chk(7'h0c, 8'(k));
		end
		i_host.write_reg(7'h0c, 8'hff);
		rd_chk(7'h0c, 8'h7f);
		for (k = 0; k < 3; k++) begin
			i_host.write_reg(7'h0c, 8'h10 | 8'(k));
			measure(hi, per);
			check(32'(hi), 32'(TC));
			check(32'(per), 32'(per_tk[k] * TC));
		end
		for (k = 0; k < 5; k++) begin
			i_host.write_reg(7'h0c, 8'h02 | 8'((k + 1) << 4));
			if (k >= 2)
				check({31'h0, cyclic_sense_hs}, 32'h1);
			measure(hi, per);
			check(32'(hi), 32'(on_tk[k] * TC));
		end
		i_host.write_reg(7'h0c, 8'h62);
		check({31'h0, cyclic_sense_hs}, 32'h1);
		i_host.write_reg(7'h0c, 8'h72);
		check({31'h0, cyclic_sense_hs}, 32'h0);
		timer_wake_en = 1'b1;
		i_host.write_reg(7'h0c, 8'h10);
		n = 0;
		hi = 0;
		repeat (100 * TC) begin
			@(negedge core_clk);
			n += int'(cyclic_wake_pulse === 1'b1);
			hi += int'(cyclic_sense_hs === 1'b1);
		end
		check(32'(n), 32'h1);
		check(32'(hi), 32'(TC));
		pulse(2);
		rd_chk(7'h0c, 8'h10);
		pulse(1);
		rd_chk(7'h0c, 8'h10);
		hs_switch_cleared = 1'b1;
		pulse(1);
		hs_switch_cleared = 1'b0;
		rd_chk(7'h0c, 8'h00);
		rd_chk(7'h0e, 8'hb0);
		check({28'h0, charge_pump_enable, gpio_cfg}, 32'hb);
		// timer restarts once an on-time is written again
		i_host.write_reg(7'h0c, 8'h10);
		measure(hi, per);
		check(32'(per), 32'(100 * TC));
		cfg_lock_level1 = 1'b1;
		i_host.write_reg(7'h0e, 8'h08);
		rd_chk(7'h0e, 8'hb8);
		pulse(0);
		rd_chk(7'h0e, 8'hb8);
		check({28'h0, charge_pump_enable, gpio_cfg}, 32'hb);
		rd_chk(7'h0c, 8'h00);
		cfg_lock_level1 = 1'b0;
		i_host.write_reg(7'h0e, 8'hb0);
		pulse(0);
		rd_chk(7'h0e, 8'h00);
		check({28'h0, charge_pump_enable, gpio_cfg}, 32'h0);
		close_out();
	end
endmodule : testbench
`default_nettype wire
